// [idc_pkg.sv]
// Shared types and constants for the input double-data-rate capture cell.
package idc_pkg;

  // ==========================================================================
  // Edge presentation modes of the capture cell.
  typedef enum logic [1:0]
  {
    IDC_SPLIT_EDGE_MODE,
    IDC_ALIGNED_EDGE_MODE,
    IDC_ALIGNED_EDGE_PIPELINED_MODE
  } idc_edge_mode_e;

  // Mode taken when the user leaves the setting alone.
  localparam idc_edge_mode_e IDC_EDGE_MODE_DEFAULT = IDC_SPLIT_EDGE_MODE;

  // ==========================================================================
  // Slice flip-flop variants.
  typedef enum logic [1:0]
  {
    IDC_FF_CE_ASYNC_CLEAR,
    IDC_FF_CE_ASYNC_PRESET,
    IDC_FF_CE_SYNC_RESET,
    IDC_FF_CE_SYNC_SET
  } idc_ff_kind_e;

  // ==========================================================================
  // Values after reset and forced values.
  localparam logic IDC_CAPTURE_RESET_VALUE = 1'h0;
  localparam logic IDC_CLEAR_VALUE = 1'h0;
  localparam logic IDC_PRESET_VALUE = 1'h1;
  localparam logic IDC_DATA_IN_INVERT_DEFAULT = 1'h0;

  // Number of flops in each reset release chain.
  localparam int IDC_RESET_SYNC_STAGES = 2;

endpackage

// [idc_slice_ff.sv]
// Single-data-rate slice flip-flop with clock enable and one control input.
`timescale 1ns/1ps
`default_nettype none

module idc_slice_ff
  import idc_pkg::*;
#(
  parameter idc_pkg::idc_ff_kind_e KIND = idc_pkg::IDC_FF_CE_ASYNC_CLEAR
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic d,
  input wire logic ctl,
  output logic q
);

  // ==========================================================================
  // Variant selection.
  // Each variant is a separate generate branch so that the control input only
  // lands in the sensitivity list of the asynchronous ones.
  generate
    if (KIND == IDC_FF_CE_ASYNC_CLEAR)
    begin : g_async_clear
      // Clear wins at once, without waiting for a clock edge.
      always_ff @(posedge clk or posedge rst or posedge ctl)
      begin
        if (rst)
          q <= IDC_CLEAR_VALUE;
        else if (ctl)
          q <= IDC_CLEAR_VALUE;
        else if (ce)
          q <= d;
      end
    end
    else if (KIND == IDC_FF_CE_ASYNC_PRESET)
    begin : g_async_preset
      // Preset wins at once, without waiting for a clock edge.
      always_ff @(posedge clk or posedge rst or posedge ctl)
      begin
        if (rst)
          q <= IDC_PRESET_VALUE;
        else if (ctl)
          q <= IDC_PRESET_VALUE;
        else if (ce)
          q <= d;
      end
    end
    else if (KIND == IDC_FF_CE_SYNC_RESET)
    begin : g_sync_reset
      // Reset is only seen at a rising edge and overrides the enable.
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          q <= IDC_CLEAR_VALUE;
        else if (ctl)
          q <= IDC_CLEAR_VALUE;
        else if (ce)
          q <= d;
      end
    end
    else
    begin : g_sync_set
      // Set is only seen at a rising edge and overrides the enable.
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          q <= IDC_PRESET_VALUE;
        else if (ctl)
          q <= IDC_PRESET_VALUE;
        else if (ce)
          q <= d;
      end
    end
  endgenerate

endmodule // idc_slice_ff

`default_nettype wire

// [idc_reset_sync.sv]
// Reset conditioner: asynchronous assertion, release on a chosen clock edge.
`timescale 1ns/1ps
`default_nettype none

module idc_reset_sync
  import idc_pkg::*;
#(
  parameter bit FALLING = 1'b0
)
(
  input wire logic clk,
  input wire logic rst,
  output logic rst_out
);

  logic [IDC_RESET_SYNC_STAGES-1:0] chain_q;

  // ==========================================================================
  // Release chain.
  // The first stage only ever loads a constant, so a glitch-free release is safe even
  // though rst itself is asynchronous.
  generate
    if (FALLING)
    begin : g_fall
      always_ff @(negedge clk or posedge rst)
      begin
        if (rst)
          chain_q <= '1;
        else
          chain_q <= {chain_q[IDC_RESET_SYNC_STAGES-2:0], 1'b0};
      end
    end
    else
    begin : g_rise
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          chain_q <= '1;
        else
          chain_q <= {chain_q[IDC_RESET_SYNC_STAGES-2:0], 1'b0};
      end
    end
  endgenerate

  // Last stage drives the local reset.
  assign rst_out = chain_q[IDC_RESET_SYNC_STAGES-1];

endmodule // idc_reset_sync

`default_nettype wire

// [idc_input_ddr_cell.sv]
// Input double-data-rate capture cell with its single-data-rate slice flops.
`timescale 1ns/1ps
`default_nettype none

module idc_input_ddr_cell
  import idc_pkg::*;
#(
  parameter idc_pkg::idc_edge_mode_e EDGE_MODE = idc_pkg::IDC_EDGE_MODE_DEFAULT,
  parameter bit DATA_IN_INVERT = idc_pkg::IDC_DATA_IN_INVERT_DEFAULT
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic data_in,
  output logic rise_data_out,
  output logic fall_data_out,
  input wire logic sdr_data_in,
  input wire logic sdr_ce,
  input wire logic sdr_clear,
  input wire logic sdr_preset,
  input wire logic sdr_sync_reset,
  input wire logic sdr_sync_set,
  output logic sdr_q_clear,
  output logic sdr_q_preset,
  output logic sdr_q_sync_reset,
  output logic sdr_q_sync_set
);

  // ==========================================================================
  // Elaboration checks.
  // Inverted input data behaves differently in silicon, so it is refused.
  if (DATA_IN_INVERT != 1'b0)
  begin : g_bad_invert
    $error("data_in_invert must be zero");
  end
  if (EDGE_MODE != IDC_SPLIT_EDGE_MODE && EDGE_MODE != IDC_ALIGNED_EDGE_MODE &&
      EDGE_MODE != IDC_ALIGNED_EDGE_PIPELINED_MODE)
  begin : g_bad_mode
    $error("unknown edge mode");
  end

  logic rst_rise;
  logic rst_fall;
  logic cap_rise_q;
  logic cap_fall_q;
  logic al_rise_q;
  logic al_fall_q;
  logic pl_rise_q;
  logic pl_fall_q;

  // ==========================================================================
  // Reset conditioning, one chain per clock edge.
  idc_reset_sync #(.FALLING(1'b0)) u_rst_rise
  (
    .clk(clk),
    .rst(rst),
    .rst_out(rst_rise)
  );

  // The falling-edge flops stand in for the complementary clock input.
  idc_reset_sync #(.FALLING(1'b1)) u_rst_fall
  (
    .clk(clk),
    .rst(rst),
    .rst_out(rst_fall)
  );

  // ==========================================================================
  // Pad capture flops.
  // These are the first flops that see the pad, so they act as the sampler;
  // a synchroniser in front would destroy the double-rate timing.
  always_ff @(posedge clk or posedge rst_rise)
  begin
    if (rst_rise)
      cap_rise_q <= IDC_CAPTURE_RESET_VALUE;
    else
      cap_rise_q <= data_in;
  end

  // Falling-edge sample.
  always_ff @(negedge clk or posedge rst_fall)
  begin
    if (rst_fall)
      cap_fall_q <= IDC_CAPTURE_RESET_VALUE;
    else
      cap_fall_q <= data_in;
  end

  // ==========================================================================
  // Aligned stage: the falling sample is moved into the rising domain.
  // The rising output loads the pad directly, so each rising sample pairs
  // with the falling sample that came before it.
  always_ff @(posedge clk or posedge rst_rise)
  begin
    if (rst_rise)
    begin
      al_rise_q <= IDC_CAPTURE_RESET_VALUE;
      al_fall_q <= IDC_CAPTURE_RESET_VALUE;
    end
    else
    begin
      al_rise_q <= data_in;
      al_fall_q <= cap_fall_q;
    end
  end

  // ==========================================================================
  // Pipelined stage: the rising sample waits one cycle for its own falling mate.
  // Trades one cycle of latency for pairs that belong to one clock period.
  always_ff @(posedge clk or posedge rst_rise)
  begin
    if (rst_rise)
    begin
      pl_rise_q <= IDC_CAPTURE_RESET_VALUE;
      pl_fall_q <= IDC_CAPTURE_RESET_VALUE;
    end
    else
    begin
      pl_rise_q <= al_rise_q;
      pl_fall_q <= cap_fall_q;
    end
  end

  // ==========================================================================
  // Output selection by the static mode; only flop outputs reach the pins.
  generate
    if (EDGE_MODE == IDC_SPLIT_EDGE_MODE)
    begin : g_split
      assign rise_data_out = cap_rise_q;
      assign fall_data_out = cap_fall_q;
    end
    else if (EDGE_MODE == IDC_ALIGNED_EDGE_MODE)
    begin : g_aligned
      assign rise_data_out = al_rise_q;
      assign fall_data_out = al_fall_q;
    end
    else
    begin : g_pipelined
      assign rise_data_out = pl_rise_q;
      assign fall_data_out = pl_fall_q;
    end
  endgenerate

  // ==========================================================================
  // Single-rate slice flops, apart from the capture flops above.
  idc_slice_ff #(.KIND(IDC_FF_CE_ASYNC_CLEAR)) u_ff_clear
  (
    .clk(clk),
    .rst(rst),
    .ce(sdr_ce),
    .d(sdr_data_in),
    .ctl(sdr_clear),
    .q(sdr_q_clear)
  );

  // Asynchronous preset variant.
  idc_slice_ff #(.KIND(IDC_FF_CE_ASYNC_PRESET)) u_ff_preset
  (
    .clk(clk),
    .rst(rst),
    .ce(sdr_ce),
    .d(sdr_data_in),
    .ctl(sdr_preset),
    .q(sdr_q_preset)
  );

  // Synchronous reset variant.
  idc_slice_ff #(.KIND(IDC_FF_CE_SYNC_RESET)) u_ff_sreset
  (
    .clk(clk),
    .rst(rst),
    .ce(sdr_ce),
    .d(sdr_data_in),
    .ctl(sdr_sync_reset),
    .q(sdr_q_sync_reset)
  );

  // Synchronous set variant.
  idc_slice_ff #(.KIND(IDC_FF_CE_SYNC_SET)) u_ff_sset
  (
    .clk(clk),
    .rst(rst),
    .ce(sdr_ce),
    .d(sdr_data_in),
    .ctl(sdr_sync_set),
    .q(sdr_q_sync_set)
  );

  // ==========================================================================
  // Assertions on capture timing.
  logic warm_q;
  logic warm_fall_q;
  logic [1:0] out_at_fall_q;

  // Marks that one clean rising edge has passed, so $past looks at real data.
  always_ff @(posedge clk or posedge rst_rise)
  begin
    if (rst_rise)
      warm_q <= 1'b0;
    else
      warm_q <= 1'b1;
  end

  // The falling chain lets go half a cycle after the rising one, so the falling
  // checks need a flag of their own or they would meet a reset sample.
  always_ff @(negedge clk or posedge rst_fall)
  begin
    if (rst_fall)
      warm_fall_q <= 1'b0;
    else
      warm_fall_q <= 1'b1;
  end

  // Output pair as it stood just before each falling edge.
  // Comparing it at the next rising edge shows whether the falling edge moved an output.
  always_ff @(negedge clk or posedge rst_fall)
  begin
    if (rst_fall)
      out_at_fall_q <= 2'h0;
    else
      out_at_fall_q <= {rise_data_out, fall_data_out};
  end

  reset_release_a: assert property (@(posedge clk)
    $fell(rst_rise) |-> !$past(rst) && !$past(rst, 2))
    else $error("capture reset released too early");

  split_rise_a: assert property (@(posedge clk) disable iff (rst_rise)
    (EDGE_MODE == IDC_SPLIT_EDGE_MODE && warm_q) |-> rise_data_out == $past(data_in))
    else $error("split rise output wrong");

  split_fall_a: assert property (@(negedge clk) disable iff (rst_fall)
    (EDGE_MODE == IDC_SPLIT_EDGE_MODE && warm_fall_q) |-> fall_data_out == $past(data_in))
    else $error("split fall output wrong");

  aligned_stable_a: assert property (@(posedge clk) disable iff (rst_rise || rst_fall)
    (EDGE_MODE != IDC_SPLIT_EDGE_MODE) |-> {rise_data_out, fall_data_out} == out_at_fall_q)
    else $error("aligned output moved on falling edge");

  aligned_pair_a: assert property (@(posedge clk) disable iff (rst_rise)
    (EDGE_MODE == IDC_ALIGNED_EDGE_MODE && warm_q) |->
      rise_data_out == $past(data_in) && fall_data_out == $past(cap_fall_q))
    else $error("aligned pair wrong");

  pipe_rise_a: assert property (@(posedge clk) disable iff (rst_rise)
    (EDGE_MODE == IDC_ALIGNED_EDGE_PIPELINED_MODE && warm_q) ##1 1'b1 |->
      rise_data_out == $past(data_in, 2))
    else $error("pipelined rise latency wrong");

  pipe_fall_a: assert property (@(posedge clk) disable iff (rst_rise)
    (EDGE_MODE == IDC_ALIGNED_EDGE_PIPELINED_MODE && warm_q) |-> fall_data_out == $past(cap_fall_q))
    else $error("pipelined fall sample wrong");

  // ==========================================================================
  // Assertions on the slice flops.
  async_clear_a: assert property (@(posedge clk) disable iff (rst)
    sdr_clear |-> sdr_q_clear == IDC_CLEAR_VALUE)
    else $error("async clear not holding zero");

  async_preset_a: assert property (@(posedge clk) disable iff (rst)
    sdr_preset |-> sdr_q_preset == IDC_PRESET_VALUE)
    else $error("async preset not holding one");

  sync_reset_a: assert property (@(posedge clk) disable iff (rst)
    (!sdr_sync_reset && !sdr_ce && sdr_q_sync_reset) ##1 sdr_sync_reset |->
      sdr_q_sync_reset ##1 !sdr_q_sync_reset)
    else $error("sync reset timing wrong");

  sync_set_a: assert property (@(posedge clk) disable iff (rst)
    (!$past(sdr_sync_set) && !$past(sdr_ce)) |-> $stable(sdr_q_sync_set))
    else $error("sync set flop changed without cause");

  sync_set_val_a: assert property (@(posedge clk) disable iff (rst)
    sdr_sync_set |=> sdr_q_sync_set)
    else $error("sync set did not force one");

  // Main scenarios.
  split_seen_c: cover property (@(posedge clk) disable iff (rst_rise)
    EDGE_MODE == IDC_SPLIT_EDGE_MODE && warm_q && rise_data_out != fall_data_out);
  pair_seen_c: cover property (@(posedge clk) disable iff (rst_rise)
    EDGE_MODE != IDC_SPLIT_EDGE_MODE && warm_q && rise_data_out && !fall_data_out);
  clear_seen_c: cover property (@(posedge clk) disable iff (rst)
    sdr_clear ##1 !sdr_clear && sdr_ce);
  set_seen_c: cover property (@(posedge clk) disable iff (rst)
    sdr_sync_set && !sdr_ce ##1 sdr_q_sync_set);

endmodule // idc_input_ddr_cell

`default_nettype wire

// [idc_pad_model.sv]
// Behavioural model of the external pin driver that feeds the capture cell.
`timescale 1ns/1ps
`default_nettype none

module idc_pad_model
#(
  parameter int SEED = 51065
)
(
  input wire logic clk,
  output logic data_in
);
  // ==========================================================================
  // Pad data stream
  int seed = SEED;

  initial data_in = 1'h0;

  // A new random bit lands 2 ns after every clock edge, so both capture edges see a settled level.
  always @(clk)
  begin
    #2;
    data_in = 1'($random(seed));
  end
endmodule // idc_pad_model

`default_nettype wire

// [idc_input_ddr_cell_tb_top.sv]
// Self-checking testbench for the input double-data-rate capture cell in all three modes.
`timescale 1ns/1ps
`default_nettype none

module idc_input_ddr_cell_tb_top;
  import idc_pkg::*;

  // ==========================================================================
  // Stimulus, outputs and bookkeeping
  logic clk = 1'h0;
  logic rst = 1'h0;
  logic data_in;
  logic sdr_data_in = 1'h0;
  logic sdr_ce = 1'h0;
  logic sdr_clear = 1'h0;
  logic sdr_preset = 1'h0;
  logic sdr_sync_reset = 1'h0;
  logic sdr_sync_set = 1'h0;
  wire [2:0] rise;
  wire [2:0] fall;
  wire [3:0] sq [3];
  logic p_now, p_old, n_now, n_pos;
  logic [3:0] e = 4'hA;
  bit run = 1'b0;
  int seed = 51065;
  int mismatches = 0;
  int comparisons = 0;

  // The clock toggles every half period of 5 ns.
  always #5 clk = ~clk;

  // ==========================================================================
  // Devices under test, one per edge mode, plus the pad driver
  idc_pad_model i_idc_pad_model (.clk(clk), .data_in(data_in));

  for (genvar g = 0; g < 3; g++)
  begin : g_mode
    idc_input_ddr_cell #(
      .EDGE_MODE(idc_edge_mode_e'(g)),
      .DATA_IN_INVERT(1'b0)
    ) i_idc_input_ddr_cell (
      .clk(clk),
      .rst(rst),
      .data_in(data_in),
      .rise_data_out(rise[g]),
      .fall_data_out(fall[g]),
      .sdr_data_in(sdr_data_in),
      .sdr_ce(sdr_ce),
      .sdr_clear(sdr_clear),
      .sdr_preset(sdr_preset),
      .sdr_sync_reset(sdr_sync_reset),
      .sdr_sync_set(sdr_sync_set),
      .sdr_q_clear(sq[g][0]),
      .sdr_q_preset(sq[g][1]),
      .sdr_q_sync_reset(sq[g][2]),
      .sdr_q_sync_set(sq[g][3])
    );
  end

  // ==========================================================================
  // Checking helpers
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %b expected %b", $time, seen, exp);
    end
  endtask

  // Expected {rise, fall}: aligned modes hold their pair from the last rising edge.
  function automatic logic [1:0] exp_pair(int m);
    if (m == 0)
      return {p_now, n_now};
    return {(m == 2) ? p_old : p_now, n_pos};
  endfunction

  task automatic test_done;
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================================
  // Slice flop controls change at the falling edge, well clear of the sampling edge.
  always @(negedge clk)
  begin
    sdr_data_in <= 1'($random(seed));
    sdr_ce <= 1'($random(seed));
    sdr_clear <= ($random(seed) & 7) == 0;
    sdr_preset <= ($random(seed) & 7) == 0;
    sdr_sync_reset <= ($random(seed) & 7) == 0;
    sdr_sync_set <= ($random(seed) & 7) == 0;
  end

  // Reference model and comparison 1 ns after every edge, once all updates have landed.
  always @(clk)
  begin
    if (clk)
    begin
      p_old = p_now;
      p_now = data_in;
      n_pos = n_now;
      if (!rst)
      begin
        e[0] = sdr_ce ? sdr_data_in : e[0];
        e[1] = sdr_ce ? sdr_data_in : e[1];
        e[2] = sdr_sync_reset ? 1'h0 : (sdr_ce ? sdr_data_in : e[2]);
        e[3] = sdr_sync_set ? 1'h1 : (sdr_ce ? sdr_data_in : e[3]);
      end
    end
    else
      n_now = data_in;
    #1;
    // Clear and preset act without waiting for an edge, so a falling-edge check catches a late one.
    if (rst)
      e = 4'hA;
    if (sdr_clear)
      e[0] = 1'h0;
    if (sdr_preset)
      e[1] = 1'h1;
    for (int m = 0; m < 3; m++)
    begin
      chk(sq[m], e);
      if (rst)
        chk({2'h0, rise[m], fall[m]}, 4'h0);
      else if (run)
        chk({2'h0, rise[m], fall[m]}, {2'h0, exp_pair(m)});
    end
  end

  // ==========================================================================
  // Main sequence: reset, random stream, a mid-run reset taken at a falling edge, more stream.
  initial
  begin
    // A non-blocking raise at time zero gives every reset flop a real edge to act on.
    rst <= 1'h1;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst <= 1'h0;
    // The capture chains need a few edges after release before pairs are meaningful.
    repeat (6) @(posedge clk);
    run = 1'b1;
    repeat (2000) @(posedge clk);
    @(negedge clk);
    run = 1'b0;
    rst <= 1'h1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst <= 1'h0;
    repeat (6) @(posedge clk);
    run = 1'b1;
    repeat (2000) @(posedge clk);
    test_done;
  end
endmodule // idc_input_ddr_cell_tb_top

`default_nettype wire
